//--- verilog/acrc_regs.svh
// Timing counts and field positions shared by both ends of the converter readout link.
`ifndef ACRC_REGS_SVH
`define ACRC_REGS_SVH

`define ACRC_CLK_PERIOD_NS      25
`define ACRC_CONV_TIME_NS       6000
`define ACRC_CONV_CYCLES        ((`ACRC_CONV_TIME_NS) / (`ACRC_CLK_PERIOD_NS))
`define ACRC_SETTLE_TIME_NS     600
`define ACRC_SETTLE_CYCLES      (((`ACRC_SETTLE_TIME_NS) + (`ACRC_CLK_PERIOD_NS) - 1) / (`ACRC_CLK_PERIOD_NS))
`define ACRC_SCLK_HALF_NS       75
`define ACRC_SCLK_HALF_CYCLES   (((`ACRC_SCLK_HALF_NS) + (`ACRC_CLK_PERIOD_NS) - 1) / (`ACRC_CLK_PERIOD_NS))
`define ACRC_CONVERT_START_N_LOW_NS      100
`define ACRC_CONVERT_START_N_LOW_CYCLES  (((`ACRC_CONVERT_START_N_LOW_NS) + (`ACRC_CLK_PERIOD_NS) - 1) / (`ACRC_CLK_PERIOD_NS))
`define ACRC_FRAME_BITS         16
`define ACRC_LEAD_ZEROS         4
`define ACRC_RESULT_BITS        12
`define ACRC_MSB                11

`endif

//--- verilog/acrc_pkg.sv
// Types for the converter readout link; only the state enum is used, by the host for its sequencer states.
package acrc_pkg;
	typedef logic [11:0] acrc_code_t;
	typedef logic [4:0]  acrc_count_t;
	typedef enum logic [1:0] {ACRC_IDLE, ACRC_START, ACRC_WAIT, ACRC_READ} acrc_host_e;
endpackage : acrc_pkg

//--- verilog/acrc_link_if.sv
// Interface carrying convert-start, serial clock and serial data between host and converter.
`timescale 1ns/10ps
interface acrc_link_if;
	logic convert_start_n;     // Host-driven convert start, active low.
	logic serial_clk;          // Host-driven serial clock.
	logic serial_result_out;   // Converter data output value.
	logic serial_result_oe_n;  // Low while the converter drives data.
	// A released line reads high, as a board pull-up would hold it.
	wire  serial_result_line = serial_result_oe_n ? 1'b1 : serial_result_out;

	modport device (input convert_start_n, input serial_clk, output serial_result_out, output serial_result_oe_n);
	modport host   (output convert_start_n, output serial_clk, input serial_result_line);
endinterface : acrc_link_if

//--- verilog/acrc_sync.sv
// Two-flop synchroniser for a single level from outside the clock domain.
`timescale 1ns/10ps
module acrc_sync (
	input  wire logic clk_sys,  // System clock.
	input  wire logic arst_n,   // Asynchronous reset, active low.
	input  wire logic rst_val,  // Reset value input, unused; both stages reset low.
	input  wire logic async_in, // Asynchronous level.
	output logic      sync_out  // Synchronised level.
);
	logic stage1;
	logic next_stage1;
	logic next_sync_out;

	// The first stage feeds only the second stage.
	always_comb begin
		next_stage1   = async_in;
		next_sync_out = stage1;
	end

	// Both stages reset low; the converter feeds levels whose idle value is low, while the host's data line idles high.
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			stage1   <= 1'b0;
			sync_out <= 1'b0;
		end else begin
			stage1   <= next_stage1;
			sync_out <= next_sync_out;
		end
	end

	logic unused_rst_val;
	assign unused_rst_val = rst_val;
endmodule : acrc_sync

//--- verilog/acrc_device.sv
// Converter end: conversion timing, output register and serial readout shift logic.
`timescale 1ns/10ps
`include "acrc_regs.svh"
// Summary of operation
// [RL1] Convert-start rising edge holds sample, starts conversion.
// [RL2] Conversion ends 6 us later; tracking resumes.
// [RL3] Result loaded into output register at 6 us.
// [RL4] Host leaves 600 ns after read.
// [RL5] Host gives exactly sixteen clock pulses.
// [RL6] After sixteenth pulse reset shifter, three-state.
// [RL7] Extra pulses keep advancing the shifter.
// [RL8] Convert-start falling edge resets the shifter.
// [RL9] Host reads never straddle convert-start falling edge.
// [RL10] Bipolar variants output two's complement codes.
// [RL11] Unipolar variants output straight binary codes.
// [RL12] Bipolar zero crossing between all-ones and zero.
// [RL13] Host avoids reads during conversion for accuracy.
// [RL14] No conversion-complete output is provided.
// [RL15] Reads during conversion still deliver valid data.
// [RL16] Serial clock no faster than 8.33 MHz.
// [RL17] Host may use square-wave convert-start status.
// [RL18] Convert-start duty cycle may be unequal.
// [RL19] Host may wait 6 us after narrow pulse.
// [RL20] Shift four zeros then result MSB first.
// [RL21] Defer output load until read ends.
// [RL22] Host holds serial clock low at convert-start fall.
// [RL23] Conversion timed by internal counter, not serial clock.
module acrc_device (
	input  wire logic          clk_sys,       // Internal conversion oscillator.
	input  wire logic          arst_n,        // Asynchronous reset, active low.
	acrc_link_if.device        link,          // Link to the host.
	input  wire logic          bipolar,       // High selects two's complement coding.
	input  wire logic [11:0]   sample_code,   // Straight binary code from the analog core.
	output logic               sample_hold,   // High while the sample stage holds.
	output logic               converting     // High during a conversion.
);
	logic        cs_sync;
	logic        sck_sync;
	logic        cs_prev;
	logic        sck_prev;
	logic [7:0]  conv_cnt;
	logic [11:0] out_reg;
	logic [11:0] held_code;
	logic [4:0]  bit_cnt;
	logic        load_pend;
	logic        dout;
	logic        dout_oe_n;
	logic        next_sample_hold;
	logic        next_converting;
	logic [7:0]  next_conv_cnt;
	logic [11:0] next_out_reg;
	logic [11:0] next_held_code;
	logic [4:0]  next_bit_cnt;
	logic        next_load_pend;
	logic        next_dout;
	logic        next_dout_oe_n;
	logic        cs_rise;
	logic        cs_fall;
	logic        sck_rise;
	logic        sck_fall;
	logic        reading;
	logic        conv_done;
	logic [11:0] coded;

	// ------------------------------------------------------------
	// Link input synchronisers
	// ------------------------------------------------------------
	// Convert start enters inverted, so its idle level equals the reset level.
	// Otherwise reset release would look like a fall and then a rise.
	acrc_sync u_sync_cs (
		.clk_sys  (clk_sys),
		.arst_n   (arst_n),
		.rst_val  (1'b0),
		.async_in (~link.convert_start_n),
		.sync_out (cs_sync)
	);
	acrc_sync u_sync_sck (
		.clk_sys  (clk_sys),
		.arst_n   (arst_n),
		.rst_val  (1'b0),
		.async_in (link.serial_clk),
		.sync_out (sck_sync)
	);

	// Edge detection on the synchronised link levels; cs_sync is high while the pin is low.
	always_comb begin
		cs_rise  = ~cs_sync & cs_prev;
		cs_fall  = cs_sync & ~cs_prev;
		sck_rise = sck_sync & ~sck_prev;
		sck_fall = ~sck_sync & sck_prev;
		// A read is in progress once a pulse was seen and sixteen are not yet done.
		reading  = (bit_cnt != 5'h00) && (bit_cnt != 5'h10);
	end

	// ------------------------------------------------------------
	// Output coding
	// ------------------------------------------------------------
	// [RL10] [RL12] two's complement: invert MSB of offset binary.
	// [RL11] straight binary passes through.
	always_comb begin
		coded = bipolar ? {~sample_code[11], sample_code[10:0]} : sample_code;
	end

	// ------------------------------------------------------------
	// Conversion timer and output register
	// ------------------------------------------------------------
	// The timer runs on the system clock only, so a stopped serial clock cannot stall it.
	always_comb begin
		next_sample_hold = sample_hold;
		next_converting  = converting;
		next_conv_cnt    = conv_cnt;
		next_held_code   = held_code;
		next_out_reg     = out_reg;
		next_load_pend   = load_pend;
		conv_done        = 1'b0;
		// [RL1] start on rising edge
		if (cs_rise && !converting) begin
			next_sample_hold = 1'b1;
			next_converting  = 1'b1;
			next_conv_cnt    = 8'h00;
			next_held_code   = coded;
		end else if (converting) begin
			// [RL23] internal counter timing
			if (conv_cnt == 8'(`ACRC_CONV_CYCLES - 1)) begin
				conv_done = 1'b1;
				// [RL2] back to tracking
				next_converting  = 1'b0;
				next_sample_hold = 1'b0;
			end else begin
				next_conv_cnt = conv_cnt + 8'h01;
			end
		end
		// [RL3] [RL15] load result at end
		if (conv_done) begin
			// [RL21] defer while reading
			if (reading) begin
				next_load_pend = 1'b1;
			end else begin
				next_out_reg = held_code;
			end
		end
		// [RL21] deferred load on read end
		if (load_pend && ((sck_fall && bit_cnt == 5'h10) || cs_fall || !reading)) begin
			next_out_reg   = held_code;
			next_load_pend = 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Serial shift logic
	// ------------------------------------------------------------
	always_comb begin
		next_bit_cnt   = bit_cnt;
		next_dout      = dout;
		next_dout_oe_n = dout_oe_n;
		// [RL8] reset on falling edge
		if (cs_fall && !sck_sync) begin
			next_bit_cnt   = 5'h00;
			next_dout      = 1'b0;
			next_dout_oe_n = 1'b1;
		end else if (sck_rise) begin
			// [RL20] zeros then MSB first
			next_dout_oe_n = 1'b0;
			if (bit_cnt[3:0] < 4'(`ACRC_LEAD_ZEROS)) begin
				next_dout = 1'b0;
			end else begin
				next_dout = out_reg[4'(`ACRC_MSB + `ACRC_LEAD_ZEROS) - bit_cnt[3:0]];
			end
			// [RL7] extra pulses advance on
			next_bit_cnt = (bit_cnt == 5'h10) ? 5'h01 : {1'b0, bit_cnt[3:0]} + 5'h01;
		end else if (sck_fall && bit_cnt == 5'h10) begin
			// [RL6] three-state after sixteenth
			next_dout_oe_n = 1'b1;
			next_dout      = 1'b0;
		end
	end

	// Registers for both groups; a stopped frame leaves data driven, as extra pulses imply.
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			cs_prev     <= 1'b0;
			sck_prev    <= 1'b0;
			sample_hold <= 1'b0;
			converting  <= 1'b0;
			conv_cnt    <= 8'h00;
			held_code   <= 12'h000;
			out_reg     <= 12'h000;
			load_pend   <= 1'b0;
			bit_cnt     <= 5'h00;
			dout        <= 1'b0;
			dout_oe_n   <= 1'b1;
		end else begin
			cs_prev     <= cs_sync;
			sck_prev    <= sck_sync;
			sample_hold <= next_sample_hold;
			converting  <= next_converting;
			conv_cnt    <= next_conv_cnt;
			held_code   <= next_held_code;
			out_reg     <= next_out_reg;
			load_pend   <= next_load_pend;
			bit_cnt     <= next_bit_cnt;
			dout        <= next_dout;
			dout_oe_n   <= next_dout_oe_n;
		end
	end

	// [RL14] no completion output
	assign link.serial_result_out  = dout;
	assign link.serial_result_oe_n = dout_oe_n;
endmodule : acrc_device

//--- verilog/acrc_host.sv
// Host end: drives convert-start, waits the conversion time, then reads sixteen bits.
`timescale 1ns/10ps
`include "acrc_regs.svh"
module acrc_host (
	input  wire logic          clk_sys,      // System clock.
	input  wire logic          arst_n,       // Asynchronous reset, active low.
	acrc_link_if.host          link,         // Link to the converter.
	input  wire logic          start,        // Pulse: begin one convert-and-read cycle.
	output logic               busy,         // High while a cycle runs.
	output logic               result_valid, // One-cycle pulse with a new result.
	output logic [11:0]        result        // Last twelve-bit result.
);
	acrc_pkg::acrc_host_e state;
	acrc_pkg::acrc_host_e next_state;
	logic        data_sync;
	logic [7:0]  tmr;
	logic [4:0]  pulses;
	logic [15:0] shreg;
	logic        cs_n;
	logic        sck;
	logic [7:0]  next_tmr;
	logic [4:0]  next_pulses;
	logic [15:0] next_shreg;
	logic        next_cs_n;
	logic        next_sck;
	logic        next_busy;
	logic        next_result_valid;
	logic [11:0] next_result;

	// ------------------------------------------------------------
	// Data input synchroniser
	// ------------------------------------------------------------
	acrc_sync u_sync_data (
		.clk_sys  (clk_sys),
		.arst_n   (arst_n),
		.rst_val  (1'b0),
		.async_in (link.serial_result_line),
		.sync_out (data_sync)
	);

	// Sequencer; data is sampled late in each high phase to cover the synchroniser delay.
	always_comb begin
		next_state        = state;
		next_tmr          = tmr;
		next_pulses       = pulses;
		next_shreg        = shreg;
		next_cs_n         = cs_n;
		next_sck          = sck;
		next_busy         = busy;
		next_result_valid = 1'b0;
		next_result       = result;
		case (state)
			acrc_pkg::ACRC_IDLE: begin
				// [RL4] [RL13] settle time before start
				if (start && tmr == 8'h00) begin
					next_state = acrc_pkg::ACRC_START;
					// [RL22] clock low at fall
					next_sck   = 1'b0;
					next_cs_n  = 1'b0;
					next_busy  = 1'b1;
					next_tmr   = 8'(`ACRC_CONVERT_START_N_LOW_CYCLES);
				end else if (tmr != 8'h00) begin
					next_tmr = tmr - 8'h01;
				end
			end
			acrc_pkg::ACRC_START: begin
				if (tmr == 8'h00) begin
					// [RL1] [RL19] rising edge then wait
					next_cs_n  = 1'b1;
					next_state = acrc_pkg::ACRC_WAIT;
					next_tmr   = 8'(`ACRC_CONV_CYCLES + 2);
				end else begin
					next_tmr = tmr - 8'h01;
				end
			end
			acrc_pkg::ACRC_WAIT: begin
				if (tmr == 8'h00) begin
					next_state  = acrc_pkg::ACRC_READ;
					next_pulses = 5'h00;
					next_tmr    = 8'(`ACRC_SCLK_HALF_CYCLES * 2);
				end else begin
					next_tmr = tmr - 8'h01;
				end
			end
			acrc_pkg::ACRC_READ: begin
				// [RL16] half period at least 75 ns
				if (tmr == 8'h00) begin
					next_tmr = 8'(`ACRC_SCLK_HALF_CYCLES * 2);
					if (!sck) begin
						// [RL5] exactly sixteen pulses
						if (pulses == 5'(`ACRC_FRAME_BITS)) begin
							next_state        = acrc_pkg::ACRC_IDLE;
							next_busy         = 1'b0;
							next_result_valid = 1'b1;
							next_result       = shreg[11:0];
							next_tmr          = 8'(`ACRC_SETTLE_CYCLES);
						end else begin
							next_sck    = 1'b1;
							next_pulses = pulses + 5'h01;
						end
					end else begin
						next_sck   = 1'b0;
						next_shreg = {shreg[14:0], data_sync};
					end
				end else begin
					next_tmr = tmr - 8'h01;
				end
			end
			default: next_state = acrc_pkg::ACRC_IDLE;
		endcase
	end

	// Registers of the sequencer.
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			state        <= acrc_pkg::ACRC_IDLE;
			tmr          <= 8'h00;
			pulses       <= 5'h00;
			shreg        <= 16'h0000;
			cs_n         <= 1'b1;
			sck          <= 1'b0;
			busy         <= 1'b0;
			result_valid <= 1'b0;
			result       <= 12'h000;
		end else begin
			state        <= next_state;
			tmr          <= next_tmr;
			pulses       <= next_pulses;
			shreg        <= next_shreg;
			cs_n         <= next_cs_n;
			sck          <= next_sck;
			busy         <= next_busy;
			result_valid <= next_result_valid;
			result       <= next_result;
		end
	end

	// [RL9] read finishes before next fall
	assign link.convert_start_n = cs_n;
	assign link.serial_clk      = sck;
endmodule : acrc_host

//--- test/acrc_checker.sv
// Concurrent checks on the wires between the host and the converter.
`timescale 1ns/10ps
`include "acrc_regs.svh"
module acrc_checker (
	input wire logic clk_sys,            // System clock.
	input wire logic arst_n,             // Asynchronous reset, active low.
	input wire logic convert_start_n,    // Convert start, active low.
	input wire logic serial_clk,         // Serial clock.
	input wire logic serial_result_out,  // Data value from the converter.
	input wire logic serial_result_oe_n  // Low while the converter drives data.
);
	// ----------------------------------------
	// Helper counters
	// ----------------------------------------
	logic       cs_q;      // Convert start one cycle ago.
	logic       sck_q;     // Serial clock one cycle ago.
	logic [4:0] n_rise;    // Serial clock rises since convert start fell.
	logic [4:0] n_fall;    // Serial clock falls since convert start fell.
	logic [8:0] since_go;  // Cycles since convert start rose, saturating.
	logic [5:0] since_rd;  // Cycles since the last serial clock fall, saturating.

	// Counters saturate so a long idle spell never wraps into a false pass.
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			cs_q     <= 1'b1;
			sck_q    <= 1'b0;
			n_rise   <= 5'h00;
			n_fall   <= 5'h00;
			since_go <= 9'h1FF;
			since_rd <= 6'h3F;
		end else begin
			cs_q  <= convert_start_n;
			sck_q <= serial_clk;
			if (cs_q && !convert_start_n) begin
				n_rise <= 5'h00;
				n_fall <= 5'h00;
			end else begin
				n_rise <= n_rise + 5'(!sck_q && serial_clk && n_rise != 5'h1F);
				n_fall <= n_fall + 5'(sck_q && !serial_clk && n_fall != 5'h1F);
			end
			since_go <= (!cs_q && convert_start_n) ? 9'h000 : since_go + 9'(since_go != 9'h1FF);
			since_rd <= (sck_q && !serial_clk) ? 6'h00 : since_rd + 6'(since_rd != 6'h3F);
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!arst_n);

	property p_sclk_low_at_fall;  $fell(convert_start_n) |-> !serial_clk; endproperty
	property p_cs_pulse;  $fell(convert_start_n) |=> !convert_start_n [*4] ##1 convert_start_n; endproperty
	property p_sclk_high;  $rose(serial_clk) |=> serial_clk [*6] ##1 !serial_clk; endproperty
	property p_no_read_in_conv;  $rose(serial_clk) |-> since_go >= `ACRC_CONV_CYCLES; endproperty
	property p_settle;  $rose(convert_start_n) |-> since_rd >= `ACRC_SETTLE_CYCLES; endproperty
	property p_lead_zero;  $rose(serial_clk) && n_rise < 4 |-> ##[1:4] (!serial_result_oe_n && !serial_result_out);
	endproperty
	property p_driven_at_fall;  $fell(serial_clk) |-> !serial_result_oe_n; endproperty
	property p_tristate;  $fell(serial_clk) && n_fall == 15 |-> ##[1:4] serial_result_oe_n; endproperty
	property p_sixteen;  $fell(convert_start_n) |-> n_fall == 0 || n_fall == 16; endproperty

	a_sclk_low_at_fall: assert property (p_sclk_low_at_fall) else $error("serial clock high at convert start fall");
	a_cs_pulse: assert property (p_cs_pulse) else $error("convert start pulse width wrong");
	a_sclk_high: assert property (p_sclk_high) else $error("serial clock high phase wrong");
	a_no_read_in_conv: assert property (p_no_read_in_conv) else $error("read began during conversion");
	a_settle: assert property (p_settle) else $error("settle gap before convert start too short");
	a_lead_zero: assert property (p_lead_zero) else $error("leading bit not a driven zero");
	a_driven_at_fall: assert property (p_driven_at_fall) else $error("data not driven at clock fall");
	a_tristate: assert property (p_tristate) else $error("data not released after last pulse");
	a_sixteen: assert property (p_sixteen) else $error("read was not sixteen pulses");

	c_start: cover property ($rose(convert_start_n));
	c_full_read: cover property (n_fall == 16 && $rose(serial_result_oe_n));
	c_read_bit: cover property ($fell(serial_clk) && n_fall == 4);
endmodule : acrc_checker

//--- test/test_adc_conversion_readout_control.sv
// Self-checking bench: host and converter back to back, plus a converter driven by hand.
`timescale 1ns/10ps
`include "acrc_regs.svh"
module test_adc_conversion_readout_control;
	logic        clk_sys;      // System clock.
	logic        arst_n;       // Reset, active low.
	logic        start;        // Host cycle request.
	logic        bipolar;      // Coding select.
	logic [11:0] sample_code;  // Code from the analog core.
	logic        busy, result_valid, sample_hold, converting;
	logic [11:0] result;
	logic [11:0] exp_q[$];     // Expected results, oldest first.
	logic [15:0] got;          // Bits read by the hand driver.
	int          num_errors = 0, n_tests = 0, conv_len = 0;
	acrc_link_if link();
	acrc_link_if link_b();

	acrc_host acrc_host_inst (.clk_sys(clk_sys), .arst_n(arst_n), .link(link), .start(start), .busy(busy),
		.result_valid(result_valid), .result(result));
	acrc_device acrc_device_inst (.clk_sys(clk_sys), .arst_n(arst_n), .link(link), .bipolar(bipolar),
		.sample_code(sample_code), .sample_hold(sample_hold), .converting(converting));
	acrc_device acrc_device_inst_b (.clk_sys(clk_sys), .arst_n(arst_n), .link(link_b), .bipolar(bipolar),
		.sample_code(sample_code), .sample_hold(), .converting());
	acrc_checker acrc_checker_inst (.clk_sys(clk_sys), .arst_n(arst_n), .convert_start_n(link.convert_start_n),
		.serial_clk(link.serial_clk), .serial_result_out(link.serial_result_out),
		.serial_result_oe_n(link.serial_result_oe_n));

	// Free-running system clock.
	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check

	task print_verdict();
		$display("comparisons %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : print_verdict

	// One host cycle; the code is scrambled once held, and poke retries start while busy.
	task automatic conv(input logic [11:0] code, input logic bp, input logic poke);
		int k;
		sample_code <= code;
		bipolar     <= bp;
		start       <= 1'b1;
		exp_q.push_back(bp ? {~code[11], code[10:0]} : code);
		@(posedge clk_sys);
		start <= 1'b0;
		for (k = 0; k < 20 && converting !== 1'b1; k++) @(posedge clk_sys);
		check({15'h0000, sample_hold}, 16'h0001);
		sample_code <= ~code;
		start       <= poke;
		@(posedge clk_sys);
		start <= 1'b0;
		for (k = 0; k < 1000 && busy !== 1'b0; k++) @(posedge clk_sys);
		check({14'h0000, busy, sample_hold}, 16'h0000);
		repeat (30) @(posedge clk_sys);
	endtask : conv

	// Hand-driven read at a 200 ns serial clock; the clock rests low between frames.
	task automatic frame_b(input logic [15:0] exp);
		repeat (16) begin
			link_b.serial_clk <= 1'b1;
			repeat (4) @(posedge clk_sys);
			got = {got[14:0], link_b.serial_result_line};
			link_b.serial_clk <= 1'b0;
			repeat (4) @(posedge clk_sys);
		end
		check(got, exp);
	endtask : frame_b

	// Narrow convert start pulse on the hand-driven link.
	task automatic go_b();
		link_b.convert_start_n <= 1'b0;
		repeat (4) @(posedge clk_sys);
		link_b.convert_start_n <= 1'b1;
		@(posedge clk_sys);
	endtask : go_b

	// ----------------------------------------
	// Scoreboard and watchdog
	// ----------------------------------------
	// Each result takes the oldest note; an unexpected one can never match 16'hFFFF.
	always @(posedge clk_sys) begin
		if (result_valid === 1'b1) begin
			if (exp_q.size() == 0) check({4'h0, result}, 16'hFFFF);
			else check({4'h0, result}, {4'h0, exp_q.pop_front()});
		end
		if (converting === 1'b1) conv_len++;
		else if (conv_len != 0) begin
			check(16'(conv_len), 16'(`ACRC_CONV_CYCLES));
			conv_len = 0;
		end
	end

	// A hang counts as a mismatch and ends the run the normal way.
	initial begin
		repeat (30000) @(posedge clk_sys);
		num_errors++;
		$display("mismatch at %0t: watchdog expired", $time);
		print_verdict();
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		logic [11:0] tbl [4];
		logic [11:0] c1, c2;
		int i;
		tbl = '{12'h000, 12'hFFF, 12'h800, 12'h7FF};
		arst_n = 1'b0;
		start = 1'b0;
		bipolar = 1'b0;
		sample_code = 12'h000;
		link_b.convert_start_n = 1'b1;
		link_b.serial_clk = 1'b0;
		c1 = 12'($urandom(32'h40EB));
		repeat (3) @(posedge clk_sys);
		arst_n <= 1'b1;
		@(posedge clk_sys);
		// Scale ends and midpoint in both codings, then random codes, one retried start.
		for (i = 0; i < 12; i++) conv((i < 8) ? tbl[i % 4] : 12'($urandom), 1'(i >> 2), 1'(i == 5));
		check(16'(exp_q.size()), 16'h0000);
		$display("test host loop done");
		// Hand-driven converter: plain read, extra pulse, reset, reads across a conversion.
		c1 = 12'($urandom);
		c2 = 12'($urandom);
		sample_code <= c1;
		bipolar     <= 1'b0;
		@(posedge clk_sys);
		go_b();
		repeat (260) @(posedge clk_sys);
		frame_b({4'h0, c1});
		check(16'(link_b.serial_result_oe_n), 16'h0001);
		link_b.serial_clk <= 1'b1;
		repeat (4) @(posedge clk_sys);
		check({14'h0000, link_b.serial_result_oe_n, link_b.serial_result_line}, 16'h0000);
		link_b.serial_clk <= 1'b0;
		sample_code       <= c2;
		repeat (4) @(posedge clk_sys);
		go_b();
		check(16'(link_b.serial_result_oe_n), 16'h0001);
		repeat (20) @(posedge clk_sys);
		frame_b({4'h0, c1});
		repeat (40) @(posedge clk_sys);
		frame_b({4'h0, c1});
		frame_b({4'h0, c2});
		// Square wave on start: the fall that ends a 6 us high phase marks fresh data.
		c1 = 12'($urandom);
		sample_code <= c1;
		go_b();
		repeat (239) @(posedge clk_sys);
		link_b.convert_start_n <= 1'b0;
		repeat (8) @(posedge clk_sys);
		frame_b({4'h0, c1});
		$display("test hand driver done");
		print_verdict();
	end
endmodule : test_adc_conversion_readout_control
